// ### design/tcp_counter.sv
// Prescaler and 16-bit modulo counter of the timer
`timescale 1ns/1ps
module tcp_counter
	import tcp_pkg::*;
(
	// Clock, reset, enable
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	// External timer clock pin
	input  wire logic tclk_pin,
	// Register side
	tcp_cnt_if.cnt    cif
);

	typedef struct packed {
		logic             sync1;
		logic             sync2;
		logic             prev;
		logic [PRE_W-1:0] pre;
		logic [CNT_W-1:0] cnt;
	} tcp_cstate_t;

	tcp_cstate_t      s_ff;
	tcp_cstate_t      nxt_s;
	logic             ext_edge;
	logic [PRE_W-1:0] mask;
	logic             tick;
	logic             wrap;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.sync1 = tclk_pin;
		nxt_s.sync2 = s_ff.sync1;
		nxt_s.prev = s_ff.sync2;
		ext_edge = s_ff.sync2 & ~s_ff.prev;
		mask = PRE_W'((7'h01 << cif.psel) - 7'h01);
		if (cif.psel == PS_EXT) begin
			tick = cif.run & ext_edge;
		end else begin
			tick = cif.run & ((s_ff.pre & mask) == mask);
		end
		wrap = tick & (s_ff.cnt == cif.modulo);
		if (cif.clr) begin
			// Counter and prescaler restart from zero, halted or not
			nxt_s.pre = '0;
			nxt_s.cnt = '0;
			tick = 1'b0;
			wrap = 1'b0;
		end else begin
			if (cif.run) begin
				nxt_s.pre = s_ff.pre + PRE_W'(1);
			end
			if (tick) begin
				nxt_s.cnt = wrap ? '0 : s_ff.cnt + CNT_W'(1);
			end
		end
		cif.tick = tick;
		cif.wrap = wrap;
		cif.count = s_ff.cnt;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_ff <= '0;
		end else if (ce) begin
			s_ff <= nxt_s;
		end
	end

endmodule

// ### design/tcp_timer.sv
// Two-channel 16-bit PWM timer with APB register access
`timescale 1ns/1ps
module tcp_timer
	import tcp_pkg::*;
(
	// Clock, reset, enable
	input  wire logic              SYS_CLK,
	input  wire logic              RST_N,
	input  wire logic              CLK_EN,
	// APB slave
	input  wire logic [ADDR_W-1:0] PADDR,
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [31:0]       PWDATA,
	output logic      [31:0]       PRDATA,
	output logic                   PREADY,
	output logic                   PSLVERR,
	// Low-power modes from system control
	input  wire logic              WAIT_MODE,
	input  wire logic              STOP_MODE,
	// External timer clock pin
	input  wire logic              TCLK_PIN,
	// Channel pins
	output logic                   CH0_PIN_O,
	output logic                   CH0_PIN_OE,
	output logic                   CH1_PIN_O,
	output logic                   CH1_PIN_OE,
	// Interrupt and wake requests
	output logic                   OVF_IRQ,
	output logic                   CH0_IRQ,
	output logic                   CH1_IRQ,
	output logic                   WAKE_REQ
);

	typedef struct packed {
		logic                   halt;
		logic                   ovf_flag;
		logic                   ovf_armed;
		logic                   ovf_ie;
		logic [2:0]             psel;
		logic                   clr;
		logic [15:0]            modulo;
		tcp_chcfg_t [1:0]       cfg;
		logic [1:0]             cflag;
		logic [1:0]             carmed;
		logic [1:0][15:0]       cval;
		logic [1:0]             pin;
		logic                   active;
		logic                   last_wr;
		logic [31:0]            rdata;
		logic                   slverr;
	} tcp_state_t;

	tcp_state_t       s_ff;
	tcp_state_t       nxt_s;
	tcp_sel_t         sel;
	logic             wr;
	logic             rd;
	logic             linked;
	logic [1:0]       drive;
	logic [1:0]       hit;
	logic [15:0]      cmp_val;
	logic [7:0]       wbyte;

	tcp_cnt_if cif ();

	tcp_counter u_counter (
		.clk      (SYS_CLK),
		.rst_n    (RST_N),
		.ce       (CLK_EN),
		.tclk_pin (TCLK_PIN),
		.cif      (cif)
	);

	function automatic tcp_sel_t decode(input logic [ADDR_W-1:0] a);
		case (a)
			OFF_TSC:  decode = SEL_TSC;
			OFF_CNT:  decode = SEL_CNT;
			OFF_MOD:  decode = SEL_MOD;
			OFF_C0SC: decode = SEL_C0SC;
			OFF_C0V:  decode = SEL_C0V;
			OFF_C1SC: decode = SEL_C1SC;
			OFF_C1V:  decode = SEL_C1V;
			default:  decode = SEL_NONE;
		endcase
	endfunction

	// Channel drives its pin in compare mode with an edge action chosen
	function automatic logic out_mode(input tcp_chcfg_t c);
		out_mode = (c.mhi | c.mlo) & (c.edge_sel != 2'h0);
	endfunction

	function automatic logic [7:0] csc_word(input tcp_chcfg_t c,
	                                        input logic f);
		csc_word = {f, c.ie, c.mhi, c.mlo, c.edge_sel, c.tov, c.max};
	endfunction

	assign cif.run = ~s_ff.halt & ~STOP_MODE;
	assign cif.clr = s_ff.clr;
	assign cif.psel = s_ff.psel;
	assign cif.modulo = s_ff.modulo;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.clr = 1'b0;
		sel = decode(PADDR);
		// Registers are out of reach while the CPU waits
		wr = PSEL & PENABLE & PWRITE & ~WAIT_MODE;
		rd = PSEL & PENABLE & ~PWRITE & ~WAIT_MODE;
		linked = s_ff.cfg[0].mhi;
		wbyte = PWDATA[7:0];
		drive = 2'b00;
		hit = 2'b00;
		cmp_val = s_ff.cval[0];

		// Timer status and control
		if (wr && sel == SEL_TSC) begin
			nxt_s.ovf_ie = wbyte[TSC_IE];
			nxt_s.halt = wbyte[TSC_HALT];
			nxt_s.psel = wbyte[TSC_PS +: 3];
			nxt_s.clr = wbyte[TSC_RST];
			if (!wbyte[TSC_OVF] && s_ff.ovf_armed) begin
				nxt_s.ovf_flag = 1'b0;
			end
			nxt_s.ovf_armed = 1'b0;
		end
		if (rd && sel == SEL_TSC && s_ff.ovf_flag) begin
			nxt_s.ovf_armed = 1'b1;
		end
		// A wrap in the clearing cycle keeps the flag and disarms
		if (cif.wrap) begin
			nxt_s.ovf_flag = 1'b1;
			nxt_s.ovf_armed = 1'b0;
		end
		if (wr && sel == SEL_MOD) begin
			nxt_s.modulo = PWDATA[15:0];
		end

		// Which channel steers the linked pair
		if (wr && sel == SEL_C0V) begin
			nxt_s.last_wr = 1'b0;
		end
		if (wr && sel == SEL_C1V) begin
			nxt_s.last_wr = 1'b1;
		end
		if (!linked) begin
			nxt_s.active = 1'b0;
		end else if (cif.wrap) begin
			nxt_s.active = nxt_s.last_wr;
		end

		for (int i = 0; i < 2; i++) begin
			// Channel registers
			if (wr && sel == (i == 0 ? SEL_C0SC : SEL_C1SC)) begin
				nxt_s.cfg[i] = tcp_chcfg_t'(wbyte[6:0]);
				if (!wbyte[CSC_FLAG] && s_ff.carmed[i]) begin
					nxt_s.cflag[i] = 1'b0;
				end
				nxt_s.carmed[i] = 1'b0;
			end
			if (rd && sel == (i == 0 ? SEL_C0SC : SEL_C1SC) &&
			    s_ff.cflag[i]) begin
				nxt_s.carmed[i] = 1'b1;
			end
			// Whole 16-bit word lands at once, no holding stage
			if (wr && sel == (i == 0 ? SEL_C0V : SEL_C1V)) begin
				nxt_s.cval[i] = PWDATA[15:0];
			end

			// Compare and pin action
			drive[i] = out_mode(s_ff.cfg[i]) &
			           ~(i == 1 && linked);
			cmp_val = (i == 0 && linked && s_ff.active) ?
			          s_ff.cval[1] : s_ff.cval[i];
			// Equality only: a value the counter already passed
			// produces no compare this period
			hit[i] = drive[i] & cif.tick &
			         (cif.count == cmp_val);
			if (drive[i] && cif.wrap && s_ff.cfg[i].tov) begin
				if (s_ff.cfg[i].max) begin
					nxt_s.pin[i] =
						(s_ff.cfg[i].edge_sel != EDGE_SET);
				end else begin
					nxt_s.pin[i] = ~s_ff.pin[i];
				end
			end
			// Without wrap toggle a forced level repeats: 0% duty on clear, 100% on set
			if (hit[i] && !(s_ff.cfg[i].max && s_ff.cfg[i].tov)) begin
				case (s_ff.cfg[i].edge_sel)
					EDGE_TOG: nxt_s.pin[i] = ~nxt_s.pin[i];
					EDGE_CLR: nxt_s.pin[i] = 1'b0;
					EDGE_SET: nxt_s.pin[i] = 1'b1;
					default:  nxt_s.pin[i] = nxt_s.pin[i];
				endcase
			end
			if (hit[i]) begin
				nxt_s.cflag[i] = 1'b1;
				nxt_s.carmed[i] = 1'b0;
			end
		end

		// Read data captured in setup so it stands through access
		if (PSEL && !PENABLE) begin
			nxt_s.slverr = (sel == SEL_NONE) | WAIT_MODE;
			case (sel)
				SEL_TSC:  nxt_s.rdata = {24'h000000, s_ff.ovf_flag,
				                         s_ff.ovf_ie, s_ff.halt, 1'b0,
				                         1'b0, s_ff.psel};
				SEL_CNT:  nxt_s.rdata = {16'h0000, cif.count};
				SEL_MOD:  nxt_s.rdata = {16'h0000, s_ff.modulo};
				SEL_C0SC: nxt_s.rdata = {24'h000000,
				                         csc_word(s_ff.cfg[0],
				                                  s_ff.cflag[0])};
				SEL_C0V:  nxt_s.rdata = {16'h0000, s_ff.cval[0]};
				SEL_C1SC: nxt_s.rdata = {24'h000000,
				                         csc_word(s_ff.cfg[1],
				                                  s_ff.cflag[1])};
				SEL_C1V:  nxt_s.rdata = {16'h0000, s_ff.cval[1]};
				default:  nxt_s.rdata = 32'h00000000;
			endcase
			if (WAIT_MODE) begin
				nxt_s.rdata = 32'h00000000;
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			s_ff <= '0;
			s_ff.halt <= HALT_RST;
			s_ff.psel <= PS_RST;
			s_ff.modulo <= MOD_RST;
			s_ff.cval <= {CVAL_RST, CVAL_RST};
		end else if (CLK_EN) begin
			s_ff <= nxt_s;
		end
	end

	// Zero-wait slave: every access completes in its first cycle
	assign PREADY = 1'b1;
	assign PRDATA = s_ff.rdata;
	assign PSLVERR = s_ff.slverr & PSEL & PENABLE;

	assign CH0_PIN_O = s_ff.pin[0];
	assign CH1_PIN_O = s_ff.pin[1];
	assign CH0_PIN_OE = out_mode(s_ff.cfg[0]);
	// Freed for general-purpose use while channels are linked
	assign CH1_PIN_OE = out_mode(s_ff.cfg[1]) & ~linked;

	assign OVF_IRQ = s_ff.ovf_flag & s_ff.ovf_ie;
	assign CH0_IRQ = s_ff.cflag[0] & s_ff.cfg[0].ie;
	// Channel 1 requests are silenced while its control is unused
	assign CH1_IRQ = s_ff.cflag[1] & s_ff.cfg[1].ie & ~linked;
	assign WAKE_REQ = OVF_IRQ | CH0_IRQ | CH1_IRQ;

endmodule

// ### pkg/tcp_cnt_if.sv
// Carrier between the register block and the counter
`timescale 1ns/1ps
interface tcp_cnt_if;
	import tcp_pkg::*;
	logic             run;
	logic             clr;
	logic [2:0]       psel;
	logic [CNT_W-1:0] modulo;
	logic             tick;
	logic [CNT_W-1:0] count;
	logic             wrap;

	modport ctl (output run, clr, psel, modulo, input tick, count, wrap);
	modport cnt (input run, clr, psel, modulo, output tick, count, wrap);
endinterface

// ### pkg/tcp_pkg.sv
// Shared constants and types of the two-channel PWM timer
package tcp_pkg;

	localparam int unsigned ADDR_W   = 8;
	localparam int unsigned CNT_W    = 16;
	localparam int unsigned PRE_W    = 6;

	// Register byte offsets
	localparam logic [7:0] OFF_TSC  = 8'h00;
	localparam logic [7:0] OFF_CNT  = 8'h04;
	localparam logic [7:0] OFF_MOD  = 8'h08;
	localparam logic [7:0] OFF_C0SC = 8'h0C;
	localparam logic [7:0] OFF_C0V  = 8'h10;
	localparam logic [7:0] OFF_C1SC = 8'h14;
	localparam logic [7:0] OFF_C1V  = 8'h18;

	// timer_status_control fields
	localparam int unsigned TSC_OVF  = 7;
	localparam int unsigned TSC_IE   = 6;
	localparam int unsigned TSC_HALT = 5;
	localparam int unsigned TSC_RST  = 4;
	localparam int unsigned TSC_PS   = 0;

	// chanN_status_control fields
	localparam int unsigned CSC_FLAG = 7;
	localparam int unsigned CSC_IE   = 6;
	localparam int unsigned CSC_MHI  = 5;
	localparam int unsigned CSC_MLO  = 4;
	localparam int unsigned CSC_EHI  = 3;
	localparam int unsigned CSC_ELO  = 2;
	localparam int unsigned CSC_TOV  = 1;
	localparam int unsigned CSC_MAX  = 0;

	// Reset values and encodings
	localparam logic [15:0] MOD_RST   = 16'hFFFF;
	localparam logic [15:0] CVAL_RST  = 16'h0000;
	localparam logic        HALT_RST  = 1'b1;
	localparam logic [2:0]  PS_RST    = 3'h0;
	localparam logic [2:0]  PS_EXT    = 3'h7;
	localparam logic [1:0]  EDGE_TOG  = 2'h1;
	localparam logic [1:0]  EDGE_CLR  = 2'h2;
	localparam logic [1:0]  EDGE_SET  = 2'h3;

	typedef enum logic [2:0] {
		SEL_TSC  = 3'b000,
		SEL_CNT  = 3'b001,
		SEL_MOD  = 3'b010,
		SEL_C0SC = 3'b011,
		SEL_C0V  = 3'b100,
		SEL_C1SC = 3'b101,
		SEL_C1V  = 3'b110,
		SEL_NONE = 3'b111
	} tcp_sel_t;

	typedef struct packed {
		logic       ie;
		logic       mhi;
		logic       mlo;
		logic [1:0] edge_sel;
		logic       tov;
		logic       max;
	} tcp_chcfg_t;

endpackage

// ### verif/tcp_pin_model.sv
// Load on a channel pin that counts the cycles it sees high
`timescale 1ns/1ps
module tcp_pin_model (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Pin and measurement
	input  wire logic pin_o,
	input  wire logic pin_oe,
	input  wire logic clr,
	output int        high_cnt
);
	logic line;
	// Pull-down: a released pin reads low, never the last driven level
	assign line = pin_oe ? pin_o : 1'b0;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) high_cnt <= 0;
		else if (clr) high_cnt <= 0;
		else if (line) high_cnt <= high_cnt + 1;
	end
endmodule

// ### verif/tcp_timer_bench.sv
// Self-checking bench of the two-channel PWM timer
`timescale 1ns/1ps
module tcp_timer_bench
	import tcp_pkg::*;
;
	localparam int PER = 10;
	logic        SYS_CLK, RST_N, PSEL, PENABLE, PWRITE, WAIT_MODE, STOP_MODE;
	logic [7:0]  PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	logic        PREADY, PSLVERR, CH0_PIN_O, CH0_PIN_OE, CH1_PIN_O, CH1_PIN_OE;
	logic        OVF_IRQ, CH0_IRQ, CH1_IRQ, WAKE_REQ, meas_clr, err;
	int          high_cnt, high_cnt1, fail_count, comparisons, cycles;
	initial begin
		SYS_CLK = 1'b0;
		forever #5 SYS_CLK = ~SYS_CLK;
	end
	tcp_timer dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CLK_EN(1'b1),
		.PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.WAIT_MODE(WAIT_MODE), .STOP_MODE(STOP_MODE), .TCLK_PIN(1'b0),
		.CH0_PIN_O(CH0_PIN_O), .CH0_PIN_OE(CH0_PIN_OE), .CH1_PIN_O(CH1_PIN_O),
		.CH1_PIN_OE(CH1_PIN_OE), .OVF_IRQ(OVF_IRQ), .CH0_IRQ(CH0_IRQ),
		.CH1_IRQ(CH1_IRQ), .WAKE_REQ(WAKE_REQ));
	tcp_pin_model load (.clk(SYS_CLK), .rst_n(RST_N), .pin_o(CH0_PIN_O),
		.pin_oe(CH0_PIN_OE), .clr(meas_clr), .high_cnt(high_cnt));
	tcp_pin_model load1 (.clk(SYS_CLK), .rst_n(RST_N), .pin_o(CH1_PIN_O),
		.pin_oe(CH1_PIN_OE), .clr(meas_clr), .high_cnt(high_cnt1));
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic check(string s, logic [31:0] e, logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic apb(logic [7:0] a, logic w, logic [31:0] d);
		int n;
		n = 0;
		@(posedge SYS_CLK);
		PADDR   <= a;
		PWRITE  <= w;
		PWDATA  <= d;
		PSEL    <= 1'b1;
		@(posedge SYS_CLK);
		PENABLE <= 1'b1;
		@(posedge SYS_CLK);
		while (PREADY !== 1'b1 && n < 50) begin
			n++;
			@(posedge SYS_CLK);
		end
		if (n == 50) fail_count++;
		rd  = PRDATA;
		err = PSLVERR;
		PSEL    <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic rdchk(string s, logic [7:0] a, logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		check(s, e, rd);
	endtask
	// Window of ten whole periods, so the start phase does not matter
	task automatic duty(string s, int e);
		repeat (20) @(posedge SYS_CLK);
		meas_clr <= 1'b1;
		@(posedge SYS_CLK);
		meas_clr <= 1'b0;
		repeat (10 * PER) @(posedge SYS_CLK);
		#1;
		check(s, e, high_cnt);
		$display("Test %s done", s);
	endtask
	always @(posedge SYS_CLK) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			fail_count++;
			complete_run();
		end
	end
	initial begin
		{PSEL, PENABLE, PWRITE, WAIT_MODE, STOP_MODE, meas_clr} = 6'h00;
		{PADDR, PWDATA} = 40'h0;
		{fail_count, comparisons, cycles} = 96'h0;
		RST_N = 1'b0;
		repeat (12) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		rdchk("status", OFF_TSC, 32'h20);
		rdchk("modulo", OFF_MOD, 32'hFFFF);
		apb(8'h1C, 1'b0, 32'h0);
		check("unmapped", 1, err);
		apb(OFF_TSC, 1'b1, 32'h30);
		apb(OFF_MOD, 1'b1, PER - 1);
		apb(OFF_C0V, 1'b1, 32'h3);
		apb(OFF_C0SC, 1'b1, 32'h5A);
		apb(OFF_TSC, 1'b1, 32'h40);
		duty("unbuf", 40);
		check("ch0 req", 1, CH0_IRQ);
		check("ovf req", 1, OVF_IRQ);
		apb(OFF_C0V, 1'b1, 32'h7);
		duty("wider", 80);
		apb(OFF_C0SC, 1'b1, 32'h18);
		duty("zero", 0);
		apb(OFF_C0SC, 1'b1, 32'h1B);
		duty("full", 10 * PER);
		apb(OFF_C0V, 1'b1, 32'h3);
		apb(OFF_C0SC, 1'b1, 32'h2A);
		duty("buf ch0", 40);
		apb(OFF_C1V, 1'b1, 32'h6);
		duty("buf ch1", 70);
		apb(OFF_C0V, 1'b1, 32'h1);
		duty("buf back", 20);
		apb(OFF_C0SC, 1'b1, 32'h3A);
		apb(OFF_C1V, 1'b1, 32'h5);
		duty("both mode", 60);
		apb(OFF_TSC, 1'b1, 32'h60);
		rdchk("flag kept", OFF_TSC, 32'hE0);
		apb(OFF_TSC, 1'b1, 32'h60);
		rdchk("flag clear", OFF_TSC, 32'h60);
		check("ovf off", 0, OVF_IRQ);
		apb(OFF_TSC, 1'b1, 32'hE0);
		rdchk("flag one", OFF_TSC, 32'h60);
		apb(OFF_TSC, 1'b1, 32'h70);
		repeat (2) @(posedge SYS_CLK);
		rdchk("cnt reset", OFF_CNT, 32'h0);
		rdchk("reset bit", OFF_TSC, 32'h60);
		$display("Test flags done");
		// Timer is already halted here, as it is not needed in wait
		WAIT_MODE <= 1'b1;
		apb(OFF_MOD, 1'b1, 32'h3);
		check("wait err", 1, err);
		rdchk("wait read", OFF_MOD, 32'h0);
		WAIT_MODE <= 1'b0;
		rdchk("mod kept", OFF_MOD, PER - 1);
		STOP_MODE <= 1'b1;
		apb(OFF_TSC, 1'b1, 32'h40);
		repeat (20) @(posedge SYS_CLK);
		rdchk("cnt stop", OFF_CNT, 32'h0);
		STOP_MODE <= 1'b0;
		duty("resume", 60);
		// Unlink and run channel 1 on its own pin
		apb(OFF_C0SC, 1'b1, 32'h00);
		apb(OFF_C1V, 1'b1, 32'h2);
		apb(OFF_C1SC, 1'b1, 32'h5A);
		duty("ch0 idle", 0);
		check("ch1 duty", 30, high_cnt1);
		check("ch1 req", 1, CH1_IRQ);
		complete_run();
	end
endmodule
bind tcp_timer tcp_timer_props u_props (.*);

// ### verif/tcp_timer_props.sv
// Port-level assertions of the two-channel PWM timer
`timescale 1ns/1ps
module tcp_timer_props
	import tcp_pkg::*;
(
	// Clock and reset
	input wire logic              SYS_CLK,
	input wire logic              RST_N,
	// Register bus
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic              PSEL,
	input wire logic              PENABLE,
	input wire logic              PWRITE,
	input wire logic [31:0]       PWDATA,
	input wire logic [31:0]       PRDATA,
	input wire logic              PSLVERR,
	// Modes, pins and requests
	input wire logic              WAIT_MODE,
	input wire logic              STOP_MODE,
	input wire logic              CH0_PIN_O,
	input wire logic              CH0_PIN_OE,
	input wire logic              CH1_PIN_OE,
	input wire logic              OVF_IRQ,
	input wire logic              CH0_IRQ,
	input wire logic              CH1_IRQ,
	input wire logic              WAKE_REQ
);
	logic [7:0] c0_ff;
	logic [7:0] c1_ff;
	logic       oie_ff;
	logic       wr;
	// Shadow of what software wrote; refused writes in wait mode are skipped
	assign wr = PSEL && PENABLE && PWRITE && !WAIT_MODE;
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			c0_ff  <= 8'h00;
			c1_ff  <= 8'h00;
			oie_ff <= 1'b0;
		end else if (wr) begin
			if (PADDR == OFF_C0SC) c0_ff <= PWDATA[7:0];
			if (PADDR == OFF_C1SC) c1_ff <= PWDATA[7:0];
			if (PADDR == OFF_TSC) oie_ff <= PWDATA[TSC_IE];
		end
	end
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	chk_wake_any: assert property (
		WAKE_REQ == (OVF_IRQ | CH0_IRQ | CH1_IRQ)) else $error("wake mismatch");
	chk_wait_error: assert property (
		PSEL && PENABLE && WAIT_MODE |-> PSLVERR) else $error("wait not refused");
	chk_wait_rdzero: assert property (
		PSEL && PENABLE && !PWRITE && WAIT_MODE |-> PRDATA == 32'h0)
		else $error("wait read not zero");
	chk_stop_freeze: assert property (
		STOP_MODE && $past(STOP_MODE) && $past(STOP_MODE, 2) && !$past(PSEL)
		|-> $stable(CH0_PIN_O)) else $error("pin moved in stop");
	chk_ch0_drive: assert property (
		CH0_PIN_OE == ((c0_ff[5] | c0_ff[4]) && c0_ff[3:2] != 2'h0))
		else $error("ch0 drive wrong");
	chk_ch1_free: assert property (
		CH1_PIN_OE == ((c1_ff[5] | c1_ff[4]) && c1_ff[3:2] != 2'h0 && !c0_ff[5]))
		else $error("ch1 drive wrong");
	chk_ovf_gate: assert property (
		OVF_IRQ |-> oie_ff) else $error("overflow request unmasked");
	chk_chan_gate: assert property (
		(CH0_IRQ |-> c0_ff[6]) and (CH1_IRQ |-> c1_ff[6] && !c0_ff[5]))
		else $error("channel request unmasked");
	chk_rst_reads0: assert property (
		PSEL && PENABLE && !PWRITE && PADDR == OFF_TSC |-> !PRDATA[TSC_RST])
		else $error("counter reset bit read as one");
	cov_ovf: cover property ($rose(OVF_IRQ));
	cov_ch0: cover property ($rose(CH0_IRQ));
	cov_wait: cover property (PSLVERR && WAIT_MODE);
endmodule
